// ==== logic/cond_ops_regs.svh ====
// Purpose: constants for the condition evaluator and operation unit
// Assumes: 32-bit datapath, byte-addressed stack
// Notes:   encodings of the condition field and stack step sizes
`ifndef COND_OPS_REGS_SVH
`define COND_OPS_REGS_SVH
// ----------------------------------------
// condition encodings
// ----------------------------------------
`define COND_ALWAYS        4'h0
`define COND_NEVER         4'h1
`define COND_HIGHER        4'h2
`define COND_LOW_OR_SAME   4'h3
`define COND_CARRY_CLEAR   4'h4
`define COND_CARRY_SET     4'h5
`define COND_NOT_EQUAL     4'h6
`define COND_EQUAL         4'h7
`define COND_OVF_CLEAR     4'h8
`define COND_OVF_SET       4'h9
`define COND_PLUS          4'hA
`define COND_MINUS         4'hB
`define COND_GE            4'hC
`define COND_LT            4'hD
`define COND_GT            4'hE
`define COND_LE            4'hF
// ----------------------------------------
// stack steps in bytes
// ----------------------------------------
`define STEP_LONG          32'h0000_0004
`define STEP_WORD          32'h0000_0002
`endif

// ==== logic/cond_ops_pkg.sv ====
// Purpose: types shared by the operation unit
// Assumes: nothing
// Notes:   operation selector values
package cond_ops_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_COND_BRANCH, OP_CALL_BRANCH, OP_ADD_PLAIN, OP_ADD_ADDR,
    OP_ADD_IMM, OP_ADD_QUICK, OP_ADD_EXTEND, OP_BCD_ADD, OP_AND,
    OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_CHANGE,
    OP_FIELD_SET, OP_FIELD_CLEAR, OP_FIELD_CHANGE, OP_FIELD_INSERT,
    OP_FIELD_EXTRACT_SIGNED, OP_FIELD_EXTRACT_UNSIGNED, OP_FIELD_FIND_ONE,
    OP_TRAP, OP_BREAK_INSN, OP_HALT_WAIT
  } op_t;
  typedef enum logic [2:0] {
    ST_RUN, ST_PUSH_FMT, ST_PUSH_PC, ST_PUSH_SR, ST_LOAD_VEC, ST_BRK_ACK, ST_HALT
  } state_t;
endpackage

// ==== logic/cond_eval.sv ====
// Purpose: combinational condition test over the flags
// Assumes: flags are valid in the same cycle
// Notes:   no state
`timescale 1ns/1ps
`include "cond_ops_regs.svh"
module cond_eval (
  input  wire logic [3:0] cond,
  input  wire logic       negative_flag,
  input  wire logic       zero_flag,
  input  wire logic       overflow_flag,
  input  wire logic       carry_flag,
  output logic            cond_true
);
  // ----------------------------------------
  // sixteen-way selection
  // ----------------------------------------
  always_comb
  begin
    case (cond)
      `COND_ALWAYS:      cond_true = 1'b1;
      `COND_NEVER:       cond_true = 1'b0;
      `COND_HIGHER:      cond_true = ~carry_flag & ~zero_flag;
      `COND_LOW_OR_SAME: cond_true = carry_flag | zero_flag;
      `COND_CARRY_CLEAR: cond_true = ~carry_flag;
      `COND_CARRY_SET:   cond_true = carry_flag;
      `COND_NOT_EQUAL:   cond_true = ~zero_flag;
      `COND_EQUAL:       cond_true = zero_flag;
      `COND_OVF_CLEAR:   cond_true = ~overflow_flag;
      `COND_OVF_SET:     cond_true = overflow_flag;
      `COND_PLUS:        cond_true = ~negative_flag;
      `COND_MINUS:       cond_true = negative_flag;
      `COND_GE:          cond_true = ~(negative_flag ^ overflow_flag);
      `COND_LT:          cond_true = negative_flag ^ overflow_flag;
      `COND_GT:          cond_true = ~(negative_flag ^ overflow_flag) & ~zero_flag;
      default:           cond_true = zero_flag | (negative_flag ^ overflow_flag);
    endcase
  end
endmodule

// ==== logic/cond_ops.sv ====
// Purpose: condition test and an early group of operation semantics
// Assumes: one operation per start pulse; memory writes are accepted at once
// Notes:   trap and breakpoint sequences take several cycles
`timescale 1ns/1ps
`include "cond_ops_regs.svh"
// Overview of operation
// - condition is formula over present flags
// - code 0000 always true, 0001 false
// - equal follows zero, not-equal its complement
// - low-or-same carry or zero; higher neither
// - carry clear and carry set tests
// - overflow clear and overflow set tests
// - plus and minus follow negative flag
// - ge when n equals v; lt otherwise
// - branch rejects always and never codes
// - true branch adds displacement, else nothing
// - call pushes pc, sp minus four
// - extended and decimal add include extend
// - trap pushes format, pc, status, loads vector
// - halt stops until an interrupt
// - bit ops load zero from bit complement
// - field set, clear, change, insert
// - field extract signed or unsigned
// - find-first-one writes bit offset
// - breakpoint acknowledges then illegal trap
// - immediate, plain and address adds
// - negative from msb, zero when all zero
module cond_ops #(
  parameter int W = 32
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                start,
  input  wire cond_ops_pkg::op_t   op,
  input  wire logic [3:0]          cond,
  input  wire logic [W-1:0]        src,
  input  wire logic [W-1:0]        dst,
  input  wire logic [W-1:0]        disp,
  input  wire logic [4:0]          bit_num,
  input  wire logic [4:0]          fld_offset,
  input  wire logic [5:0]          fld_width,
  input  wire logic [W-1:0]        vector_pc,
  input  wire logic [15:0]         format_word,
  input  wire logic [15:0]         status_word,
  input  wire logic                interrupt_req,
  input  wire logic                negative_flag,
  input  wire logic                zero_flag,
  input  wire logic                overflow_flag,
  input  wire logic                carry_flag,
  input  wire logic                extend_flag,
  output logic                     cond_true,
  output logic [W-1:0]             pc_reg,
  output logic [W-1:0]             sp_reg,
  output logic [W-1:0]             result_reg,
  output logic                     result_valid_reg,
  output logic                     res_negative_reg,
  output logic                     res_zero_reg,
  output logic                     res_carry_reg,
  output logic                     illegal_reg,
  output logic                     mem_write_reg,
  output logic [W-1:0]             mem_addr_reg,
  output logic [W-1:0]             mem_data_reg,
  output logic                     brk_ack_reg,
  output logic                     busy,
  output logic                     halted
);
  // ----------------------------------------
  // condition evaluator
  // ----------------------------------------
  cond_eval u_eval (
    .cond          (cond),
    .negative_flag (negative_flag),
    .zero_flag     (zero_flag),
    .overflow_flag (overflow_flag),
    .carry_flag    (carry_flag),
    .cond_true     (cond_true)
  );

  cond_ops_pkg::state_t state_reg;
  logic [W-1:0]         fmask;
  logic [W-1:0]         fdata;
  logic [W-1:0]         res_next;
  logic                 carry_next;
  logic [W:0]           sum;
  logic [W-1:0]         bcd;
  logic                 bcd_c;
  logic                 branch_ok;
  logic [5:0]           ffo;
  logic [5:0]           wid;

  assign busy   = (state_reg != cond_ops_pkg::ST_RUN);
  assign halted = (state_reg == cond_ops_pkg::ST_HALT);
  // width 0 means 32 bits
  assign wid    = (fld_width == 6'h00) ? 6'h20 : fld_width;
  // ----------------------------------------
  // field mask, offset from msb
  // ----------------------------------------
  always_comb
  begin
    fmask = '0;
    for (int i = 0; i < W; i++)
    begin
      if ((i < W - int'(fld_offset)) && (i >= W - int'(fld_offset) - int'(wid)))
        fmask[i] = 1'b1;
    end
  end
  // extract and scan read the source operand, not the destination
  assign fdata = (src & fmask) >> (W - int'(fld_offset) - int'(wid) < 0 ? 0
               : W - int'(fld_offset) - int'(wid));
  // ----------------------------------------
  // find first one, scans from msb of field
  // ----------------------------------------
  always_comb
  begin
    ffo = 6'(fld_offset) + wid;
    for (int i = 0; i < W; i++)
    begin
      if (fmask[i] && src[i])
        ffo = 6'(W - 1 - i);
    end
  end
  // ----------------------------------------
  // decimal add, digit by digit
  // ----------------------------------------
  always_comb
  begin
    logic [4:0] d;
    logic       c;
    d   = 5'h00;
    c   = extend_flag;
    bcd = '0;
    for (int k = 0; k < 2; k++)
    begin
      d = 5'(src[k*4 +: 4]) + 5'(dst[k*4 +: 4]) + 5'(c);
      if (d > 5'h09)
        d = d + 5'h06;
      bcd[k*4 +: 4] = d[3:0];
      c = d[4];
    end
    bcd_c = c;
  end
  // ----------------------------------------
  // result select
  // ----------------------------------------
  always_comb
  begin
    sum        = '0;
    carry_next = 1'b0;
    res_next   = dst;
    case (op)
      cond_ops_pkg::OP_ADD_PLAIN, cond_ops_pkg::OP_ADD_ADDR,
      cond_ops_pkg::OP_ADD_IMM, cond_ops_pkg::OP_ADD_QUICK:
      begin
        sum        = {1'b0, src} + {1'b0, dst};
        res_next   = sum[W-1:0];
        carry_next = sum[W];
      end
      cond_ops_pkg::OP_ADD_EXTEND:
      begin
        sum        = {1'b0, src} + {1'b0, dst} + (W+1)'(extend_flag);
        res_next   = sum[W-1:0];
        carry_next = sum[W];
      end
      cond_ops_pkg::OP_BCD_ADD:
      begin
        res_next   = {dst[W-1:8], bcd[7:0]};
        carry_next = bcd_c;
      end
      cond_ops_pkg::OP_AND:           res_next = src & dst;
      cond_ops_pkg::OP_BIT_SET:       res_next = dst | (32'h0000_0001 << bit_num);
      cond_ops_pkg::OP_BIT_CLEAR:     res_next = dst & ~(32'h0000_0001 << bit_num);
      cond_ops_pkg::OP_BIT_CHANGE:    res_next = dst ^ (32'h0000_0001 << bit_num);
      cond_ops_pkg::OP_FIELD_SET:     res_next = dst | fmask;
      cond_ops_pkg::OP_FIELD_CLEAR:   res_next = dst & ~fmask;
      cond_ops_pkg::OP_FIELD_CHANGE:  res_next = dst ^ fmask;
      cond_ops_pkg::OP_FIELD_INSERT:
        res_next = (dst & ~fmask) | ((src << (W - int'(fld_offset) - int'(wid))) & fmask);
      cond_ops_pkg::OP_FIELD_EXTRACT_UNSIGNED: res_next = fdata;
      cond_ops_pkg::OP_FIELD_EXTRACT_SIGNED:
        res_next = W'($signed(fdata << (W - int'(wid))) >>> (W - int'(wid)));
      cond_ops_pkg::OP_FIELD_FIND_ONE: res_next = W'(ffo);
      default:                        res_next = dst;
    endcase
  end

  // always and never are not branch conditions
  assign branch_ok = cond_true && (cond != `COND_ALWAYS) && (cond != `COND_NEVER);
  // ----------------------------------------
  // results and flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_reg       <= '0;
      result_valid_reg <= 1'b0;
      res_negative_reg <= 1'b0;
      res_zero_reg     <= 1'b0;
      res_carry_reg    <= 1'b0;
    end
    else
    begin
      result_valid_reg <= 1'b0;
      if (start && !busy && op != cond_ops_pkg::OP_NONE && op < cond_ops_pkg::OP_TRAP
          && op != cond_ops_pkg::OP_COND_BRANCH && op != cond_ops_pkg::OP_CALL_BRANCH)
      begin
        result_reg       <= res_next;
        result_valid_reg <= 1'b1;
        res_carry_reg    <= carry_next;
        res_negative_reg <= res_next[W-1];
        res_zero_reg     <= (res_next == '0);
        if (op >= cond_ops_pkg::OP_BIT_TEST && op <= cond_ops_pkg::OP_BIT_CHANGE)
          res_zero_reg <= ~dst[bit_num];
      end
    end
  end
  // ----------------------------------------
  // program flow and stack sequence
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= cond_ops_pkg::ST_RUN;
      pc_reg        <= '0;
      sp_reg        <= '0;
      illegal_reg   <= 1'b0;
      mem_write_reg <= 1'b0;
      mem_addr_reg  <= '0;
      mem_data_reg  <= '0;
      brk_ack_reg   <= 1'b0;
    end
    else
    begin
      mem_write_reg <= 1'b0;
      brk_ack_reg   <= 1'b0;
      case (state_reg)
        cond_ops_pkg::ST_RUN:
          if (start)
          begin
            illegal_reg <= 1'b0;
            case (op)
              cond_ops_pkg::OP_COND_BRANCH:
                if (branch_ok)
                  pc_reg <= pc_reg + disp;
              cond_ops_pkg::OP_CALL_BRANCH:
              begin
                sp_reg        <= sp_reg - `STEP_LONG;
                mem_addr_reg  <= sp_reg - `STEP_LONG;
                mem_data_reg  <= pc_reg;
                mem_write_reg <= 1'b1;
                pc_reg        <= pc_reg + disp;
              end
              cond_ops_pkg::OP_TRAP:       state_reg <= cond_ops_pkg::ST_PUSH_FMT;
              cond_ops_pkg::OP_BREAK_INSN:
              begin
                brk_ack_reg <= 1'b1;
                state_reg   <= cond_ops_pkg::ST_BRK_ACK;
              end
              cond_ops_pkg::OP_HALT_WAIT:  state_reg <= cond_ops_pkg::ST_HALT;
              default:                     state_reg <= cond_ops_pkg::ST_RUN;
            endcase
          end
        cond_ops_pkg::ST_BRK_ACK:
        begin
          illegal_reg <= 1'b1;
          state_reg   <= cond_ops_pkg::ST_PUSH_FMT;
        end
        cond_ops_pkg::ST_PUSH_FMT:
        begin
          mem_addr_reg  <= sp_reg;
          mem_data_reg  <= W'(format_word);
          mem_write_reg <= 1'b1;
          sp_reg        <= sp_reg - `STEP_WORD;
          state_reg     <= cond_ops_pkg::ST_PUSH_PC;
        end
        cond_ops_pkg::ST_PUSH_PC:
        begin
          mem_addr_reg  <= sp_reg;
          mem_data_reg  <= pc_reg;
          mem_write_reg <= 1'b1;
          sp_reg        <= sp_reg - `STEP_LONG;
          state_reg     <= cond_ops_pkg::ST_PUSH_SR;
        end
        cond_ops_pkg::ST_PUSH_SR:
        begin
          mem_addr_reg  <= sp_reg;
          mem_data_reg  <= W'(status_word);
          mem_write_reg <= 1'b1;
          sp_reg        <= sp_reg - `STEP_WORD;
          state_reg     <= cond_ops_pkg::ST_LOAD_VEC;
        end
        cond_ops_pkg::ST_LOAD_VEC:
        begin
          pc_reg    <= vector_pc;
          state_reg <= cond_ops_pkg::ST_RUN;
        end
        cond_ops_pkg::ST_HALT:
          // only an interrupt leaves the stopped state
          if (interrupt_req)
            state_reg <= cond_ops_pkg::ST_RUN;
        default: state_reg <= cond_ops_pkg::ST_RUN;
      endcase
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_branch_taken: assert property (@(posedge clk) disable iff (!resetn)
    start && !busy && op == cond_ops_pkg::OP_COND_BRANCH && branch_ok
    |=> pc_reg == $past(pc_reg) + $past(disp)) else $error("branch pc wrong");
  a_branch_not: assert property (@(posedge clk) disable iff (!resetn)
    start && !busy && op == cond_ops_pkg::OP_COND_BRANCH && !branch_ok
    |=> $stable(pc_reg)) else $error("untaken branch moved pc");
  a_branch_never: assert property (@(posedge clk) disable iff (!resetn)
    cond == `COND_ALWAYS |-> !branch_ok) else $error("always code branched");
  a_call_push: assert property (@(posedge clk) disable iff (!resetn)
    start && !busy && op == cond_ops_pkg::OP_CALL_BRANCH
    |=> sp_reg == $past(sp_reg) - `STEP_LONG && mem_write_reg && mem_data_reg == $past(pc_reg))
    else $error("call push wrong");
  a_trap_stack: assert property (@(posedge clk) disable iff (!resetn)
    start && !busy && op == cond_ops_pkg::OP_TRAP
    |-> ##4 sp_reg == $past(sp_reg, 4) - 32'h0000_0008 ##1 pc_reg == $past(vector_pc))
    else $error("trap stacking wrong");
  a_halt_hold: assert property (@(posedge clk) disable iff (!resetn)
    halted && !interrupt_req |=> halted) else $error("left halt early");
  a_bit_zero: assert property (@(posedge clk) disable iff (!resetn)
    start && !busy && op == cond_ops_pkg::OP_BIT_TEST
    |=> res_zero_reg == ((($past(dst) >> $past(bit_num)) & W'(1)) == '0)
        && result_reg == $past(dst))
    else $error("bit test wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    result_valid_reg && op != cond_ops_pkg::OP_BIT_TEST && $past(op) == cond_ops_pkg::OP_AND
    |-> res_zero_reg == (result_reg == '0) && res_negative_reg == result_reg[W-1])
    else $error("result flags wrong");
  a_cond_eq: assert property (@(posedge clk) disable iff (!resetn)
    cond == `COND_EQUAL |-> cond_true == zero_flag) else $error("equal test wrong");
  a_cond_ne: assert property (@(posedge clk) disable iff (!resetn)
    cond == `COND_NOT_EQUAL |-> cond_true == !zero_flag) else $error("not-equal test wrong");
  a_brk_order: assert property (@(posedge clk) disable iff (!resetn)
    brk_ack_reg |=> illegal_reg ##1 mem_write_reg) else $error("breakpoint order");
endmodule

// ==== dv/tb_cond_ops.sv ====
// Purpose: self-checking bench for the condition test and operation unit
// Assumes: inputs driven by nba at rising clk, results read 1 ns later
// Notes:   expectations computed here, never read back from the design
`timescale 1ns/1ps
`include "cond_ops_regs.svh"
module tb_cond_ops;
  // ----------------------------------------
  // clock, reset, stimulus signals
  // ----------------------------------------
  logic                clk           = 1'b0;
  logic                resetn        = 1'b0;
  logic                start         = 1'b0;
  cond_ops_pkg::op_t   op            = cond_ops_pkg::OP_NONE;
  logic [3:0]          cond          = 4'h0;
  logic [31:0]         src           = 32'h0000_0000;
  logic [31:0]         dst           = 32'h0000_0000;
  logic [31:0]         disp          = 32'h0000_0000;
  logic [4:0]          bit_num       = 5'h00;
  logic [4:0]          fld_offset    = 5'h00;
  logic [5:0]          fld_width     = 6'h00;
  logic [31:0]         vector_pc     = 32'h0000_4000;
  logic [15:0]         format_word   = 16'h0000;
  logic [15:0]         status_word   = 16'h0000;
  logic                interrupt_req = 1'b0;
  logic [3:0]          nzvc          = 4'h0;
  logic                extend_flag   = 1'b0;
  logic                cond_true, result_valid_reg, res_negative_reg, res_zero_reg;
  logic                res_carry_reg, illegal_reg, mem_write_reg, brk_ack_reg, busy, halted;
  logic [31:0]         pc_reg, sp_reg, result_reg, mem_addr_reg, mem_data_reg;
  int                  n_errors      = 0;
  int                  n_checks      = 0;
  always #12.5 clk = ~clk;
  cond_ops #(.W(32)) dut (.clk(clk), .resetn(resetn), .start(start), .op(op), .cond(cond),
    .src(src), .dst(dst), .disp(disp), .bit_num(bit_num), .fld_offset(fld_offset),
    .fld_width(fld_width), .vector_pc(vector_pc), .format_word(format_word),
    .status_word(status_word), .interrupt_req(interrupt_req), .negative_flag(nzvc[3]),
    .zero_flag(nzvc[2]), .overflow_flag(nzvc[1]), .carry_flag(nzvc[0]),
    .extend_flag(extend_flag), .cond_true(cond_true), .pc_reg(pc_reg), .sp_reg(sp_reg),
    .result_reg(result_reg), .result_valid_reg(result_valid_reg),
    .res_negative_reg(res_negative_reg), .res_zero_reg(res_zero_reg),
    .res_carry_reg(res_carry_reg), .illegal_reg(illegal_reg), .mem_write_reg(mem_write_reg),
    .mem_addr_reg(mem_addr_reg), .mem_data_reg(mem_data_reg), .brk_ack_reg(brk_ack_reg),
    .busy(busy), .halted(halted));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // leaves the bench 1 ns into the cycle after the taking edge
  task automatic run_op(input cond_ops_pkg::op_t o, input logic [31:0] s, input logic [31:0] d,
                        input logic [4:0] fo, input logic [5:0] fw, input logic [4:0] bn);
    @(posedge clk);
    start      <= 1'b1;
    op         <= o;
    src        <= s;
    dst        <= d;
    fld_offset <= fo;
    fld_width  <= fw;
    bit_num    <= bn;
    @(posedge clk);
    start      <= 1'b0;
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every code against every flag pattern, result same cycle
  task automatic test_cond_table();
    logic n, z, v, c, e;
    for (int k = 0; k < 256; k++)
    begin
      @(posedge clk);
      cond <= k[7:4];
      nzvc <= k[3:0];
      #1;
      {n, z, v, c} = k[3:0];
      case (k[7:4])
        4'h0: e = 1'b1;
        4'h1: e = 1'b0;
        4'h2: e = !c && !z;
        4'h3: e = c || z;
        4'h4: e = !c;
        4'h5: e = c;
        4'h6: e = !z;
        4'h7: e = z;
        4'h8: e = !v;
        4'h9: e = v;
        4'hA: e = !n;
        4'hB: e = n;
        4'hC: e = (n == v);
        4'hD: e = (n != v);
        4'hE: e = (n == v) && !z;
        default: e = z || (n != v);
      endcase
      check("cond_true", {31'h0, cond_true}, {31'h0, e});
    end
    $display("test cond_table done");
  endtask
  // taken, not taken, then the two codes a branch must refuse
  task automatic test_branch();
    logic [3:0] codes [4] = '{`COND_EQUAL, `COND_EQUAL, `COND_ALWAYS, `COND_NEVER};
    @(posedge clk);
    disp <= 32'h0000_0100;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      cond <= codes[i];
      nzvc <= (i == 0) ? 4'h4 : 4'h0;
      run_op(cond_ops_pkg::OP_COND_BRANCH, 32'h0000_0000, 32'h0000_0000, 5'h00, 6'h00, 5'h00);
      check("branch pc", pc_reg, 32'h0000_0100);
    end
    $display("test branch done");
  endtask
  // call then trap; stack pointer walks down from zero
  task automatic test_call_trap();
    @(posedge clk);
    disp        <= 32'h0000_0020;
    format_word <= 16'h5A3C;
    status_word <= 16'h2704;
    run_op(cond_ops_pkg::OP_CALL_BRANCH, 32'h0000_0000, 32'h0000_0000, 5'h00, 6'h00, 5'h00);
    check("call sp", sp_reg, 32'hFFFF_FFFC);
    check("call write", {31'h0, mem_write_reg}, 32'h0000_0001);
    check("call addr", mem_addr_reg, 32'hFFFF_FFFC);
    check("call data", mem_data_reg, 32'h0000_0100);
    check("call pc", pc_reg, 32'h0000_0120);
    run_op(cond_ops_pkg::OP_TRAP, 32'h0000_0000, 32'h0000_0000, 5'h00, 6'h00, 5'h00);
    check("trap busy", {31'h0, busy}, 32'h0000_0001);
    step();
    check("fmt addr", mem_addr_reg, 32'hFFFF_FFFC);
    check("fmt data", {16'h0, mem_data_reg[15:0]}, 32'h0000_5A3C);
    step();
    check("pc addr", mem_addr_reg, 32'hFFFF_FFFA);
    check("pc data", mem_data_reg, 32'h0000_0120);
    step();
    check("sr addr", mem_addr_reg, 32'hFFFF_FFF6);
    check("sr data", {16'h0, mem_data_reg[15:0]}, 32'h0000_2704);
    check("sr write", {31'h0, mem_write_reg}, 32'h0000_0001);
    step();
    check("trap pc", pc_reg, 32'h0000_4000);
    check("trap sp", sp_reg, 32'hFFFF_FFF4);
    $display("test call_trap done");
  endtask
  // adds, with flag results at the sign boundary and at zero
  task automatic test_adds();
    @(posedge clk);
    extend_flag <= 1'b1;
    run_op(cond_ops_pkg::OP_ADD_PLAIN, 32'h0000_0001, 32'h7FFF_FFFF, 5'h00, 6'h00, 5'h00);
    check("add plain", result_reg, 32'h8000_0000);
    check("add neg", {31'h0, res_negative_reg}, 32'h0000_0001);
    check("add zero", {31'h0, res_zero_reg}, 32'h0000_0000);
    check("add valid", {31'h0, result_valid_reg}, 32'h0000_0001);
    run_op(cond_ops_pkg::OP_ADD_IMM, 32'h0000_0010, 32'h0000_0005, 5'h00, 6'h00, 5'h00);
    check("add imm", result_reg, 32'h0000_0015);
    run_op(cond_ops_pkg::OP_ADD_EXTEND, 32'h0000_0000, 32'hFFFF_FFFF, 5'h00, 6'h00, 5'h00);
    check("add ext", result_reg, 32'h0000_0000);
    check("ext zero", {31'h0, res_zero_reg}, 32'h0000_0001);
    check("ext carry", {31'h0, res_carry_reg}, 32'h0000_0001);
    run_op(cond_ops_pkg::OP_BCD_ADD, 32'h0000_0038, 32'h0000_0045, 5'h00, 6'h00, 5'h00);
    check("bcd add", {24'h0, result_reg[7:0]}, 32'h0000_0084);
    check("bcd carry", {31'h0, res_carry_reg}, 32'h0000_0000);
    run_op(cond_ops_pkg::OP_AND, 32'hF0F0_0000, 32'h0F0F_0000, 5'h00, 6'h00, 5'h00);
    check("and", result_reg, 32'h0000_0000);
    check("and zero", {31'h0, res_zero_reg}, 32'h0000_0001);
    $display("test adds done");
  endtask
  // each bit op on a set bit 31 and on a clear bit 0
  task automatic test_bits();
    cond_ops_pkg::op_t ops [4] = '{cond_ops_pkg::OP_BIT_TEST, cond_ops_pkg::OP_BIT_SET,
                                   cond_ops_pkg::OP_BIT_CLEAR, cond_ops_pkg::OP_BIT_CHANGE};
    logic [31:0] hi [4] = '{32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] lo [4] = '{32'h8000_0000, 32'h8000_0001, 32'h8000_0000, 32'h8000_0001};
    for (int i = 0; i < 4; i++)
    begin
      run_op(ops[i], 32'h0000_0000, 32'h8000_0000, 5'h00, 6'h00, 5'd31);
      check("bit hi", result_reg, hi[i]);
      check("bit hi z", {31'h0, res_zero_reg}, 32'h0000_0000);
      run_op(ops[i], 32'h0000_0000, 32'h8000_0000, 5'h00, 6'h00, 5'd0);
      check("bit lo", result_reg, lo[i]);
      check("bit lo z", {31'h0, res_zero_reg}, 32'h0000_0001);
    end
    $display("test bits done");
  endtask
  // field at offset 4 width 8 covers bits 27 down to 20
  task automatic test_fields();
    cond_ops_pkg::op_t ops [8] = '{cond_ops_pkg::OP_FIELD_SET, cond_ops_pkg::OP_FIELD_CLEAR,
      cond_ops_pkg::OP_FIELD_CHANGE, cond_ops_pkg::OP_FIELD_INSERT,
      cond_ops_pkg::OP_FIELD_EXTRACT_UNSIGNED, cond_ops_pkg::OP_FIELD_EXTRACT_SIGNED,
      cond_ops_pkg::OP_FIELD_FIND_ONE, cond_ops_pkg::OP_FIELD_FIND_ONE};
    logic [31:0] s [8] = '{32'h0, 32'h0, 32'h0, 32'h0000_00A5, 32'h0A50_0000, 32'h0A50_0000,
                           32'h0010_0000, 32'hF00F_FFFF};
    logic [31:0] d [8] = '{32'h0, 32'hFFFF_FFFF, 32'h0F00_0000, 32'h0, 32'h0, 32'h0, 32'h0,
                           32'h0};
    logic [31:0] e [8] = '{32'h0FF0_0000, 32'hF00F_FFFF, 32'h00F0_0000, 32'h0A50_0000,
                           32'h0000_00A5, 32'hFFFF_FFA5, 32'h0000_000B, 32'h0000_000C};
    for (int i = 0; i < 8; i++)
    begin
      run_op(ops[i], s[i], d[i], 5'd4, 6'd8, 5'h00);
      check("field", result_reg, e[i]);
    end
    $display("test fields done");
  endtask
  // stop holds until an interrupt; breakpoint acks then goes illegal
  task automatic test_halt_break();
    run_op(cond_ops_pkg::OP_HALT_WAIT, 32'h0000_0000, 32'h0000_0000, 5'h00, 6'h00, 5'h00);
    repeat (20) step();
    check("halted", {31'h0, halted}, 32'h0000_0001);
    @(posedge clk);
    interrupt_req <= 1'b1;
    for (int i = 0; i < 8 && halted !== 1'b0; i++)
      step();
    check("woken", {31'h0, halted}, 32'h0000_0000);
    @(posedge clk);
    interrupt_req <= 1'b0;
    vector_pc     <= 32'h0000_5000;
    run_op(cond_ops_pkg::OP_BREAK_INSN, 32'h0000_0000, 32'h0000_0000, 5'h00, 6'h00, 5'h00);
    check("brk ack", {31'h0, brk_ack_reg}, 32'h0000_0001);
    check("early illegal", {31'h0, illegal_reg}, 32'h0000_0000);
    step();
    check("illegal", {31'h0, illegal_reg}, 32'h0000_0001);
    for (int i = 0; i < 12 && busy !== 1'b0; i++)
      step();
    check("brk trap pc", pc_reg, 32'h0000_5000);
    $display("test halt_break done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    test_cond_table();
    test_branch();
    test_call_trap();
    test_adds();
    test_bits();
    test_fields();
    test_halt_break();
    final_report();
  end
  // whole run is well under 600 cycles; this leaves ample margin
  initial
  begin
    #50_000;
    n_errors++;
    final_report();
  end
endmodule
